/* inc/oag_pkg.sv */
// operand address generation: shared constants, opcodes and state type
// assumes a byte-wide memory bus with 16-bit addresses on one clock
package oag_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam logic [7:0] REG_RESET = 8'h00;

  // register file codes, as carried in opcode fields
  localparam logic [2:0] REG_H = 3'h4;
  localparam logic [2:0] REG_L = 3'h5;
  localparam logic [2:0] REG_M = 3'h6;
  localparam logic [2:0] REG_A = 3'h7;
  localparam logic [1:0] PAIR_SP = 2'h3;

  // fixed opcodes
  localparam logic [7:0] OP_NO_OPERATION = 8'h00;
  localparam logic [7:0] OP_LOAD_ACC_DIRECT = 8'h3a;
  localparam logic [7:0] OP_STA = 8'h32;
  localparam logic [7:0] OP_STORE_VIA_SECOND = 8'h02;
  localparam logic [7:0] OP_STORE_VIA_THIRD = 8'h12;
  localparam logic [7:0] OP_LOAD_VIA_SECOND = 8'h0a;
  localparam logic [7:0] OP_LOAD_VIA_THIRD = 8'h1a;
  localparam logic [7:0] OP_ROTATE_LEFT_CARRY = 8'h17;
  localparam logic [7:0] OP_JUMP_CARRY_CLEAR = 8'hd2;
  localparam logic [7:0] OP_JNZ = 8'hc2;
  localparam logic [7:0] OP_JMP = 8'hc3;
  localparam logic [7:0] OP_STORE_PAIR_DIRECT = 8'h22;
  localparam logic [7:0] OP_CALL = 8'hcd;
  localparam logic [7:0] OP_RET = 8'hc9;
  localparam logic [7:0] OP_ACI = 8'hce;

  // opcode families: (op & mask) == pattern
  localparam logic [7:0] MASK_PAIR = 8'hcf;
  localparam logic [7:0] MASK_REG = 8'hc7;
  localparam logic [7:0] PAT_LOAD_PAIR_IMM = 8'h01;
  localparam logic [7:0] PAT_DOUBLE_ADD = 8'h09;
  localparam logic [7:0] PAT_PUSH = 8'hc5;
  localparam logic [7:0] PAT_POP = 8'hc1;
  localparam logic [7:0] PAT_MOVE_IMM = 8'h06;
  localparam logic [7:0] PAT_DCR = 8'h05;

  typedef enum logic [2:0] {
    ST_FETCH = 3'b000,
    ST_IMM_LO = 3'b001,
    ST_IMM_HI = 3'b010,
    ST_EXEC = 3'b011,
    ST_MEM = 3'b100
  } oag_state_type;

endpackage : oag_pkg

/* testbench/oag_mem_model.sv */
// memory partner: byte store answering each held request after a set wait
// assumes one request at a time, held until its ack
`timescale 1ns/1ps
`default_nettype none

module oag_mem_model
  import oag_pkg::*;
(
  input wire logic mclk,
  input wire logic [1:0] wait_cyc,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [DATA_W-1:0] mem_wdata,
  output logic [DATA_W-1:0] mem_rdata,
  output logic mem_ack
);
  logic [7:0] ram [0:65535];
  logic [1:0] cnt_q;

  initial begin
    mem_ack = 1'b0;
    mem_rdata = 8'h00;
    cnt_q = 2'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    if (mem_req && !mem_ack && cnt_q == wait_cyc) begin
      mem_ack <= 1'b1;
      mem_rdata <= ram[mem_addr];
      cnt_q <= 2'h0;
      if (mem_we) begin
        ram[mem_addr] <= mem_wdata;
      end
    end else begin
      // data line not driven: keep it moving so no stale byte looks valid
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      cnt_q <= (mem_req && !mem_ack) ? cnt_q + 2'h1 : 2'h0;
    end
  end
endmodule : oag_mem_model

`default_nettype wire

/* testbench/oag_props.sv */
// checker: bus order and operand address relations of the decode core
// assumes it is bound to oag_core and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none

module oag_props
  import oag_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [DATA_W-1:0] mem_wdata,
  input wire logic [DATA_W-1:0] mem_rdata,
  input wire logic mem_ack,
  input wire logic opcode_fetch,
  input wire logic unknown_opcode
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  logic ack;
  logic [7:0] op_q, d0_q, d1_q;
  logic [1:0] cnt_q;
  logic [15:0] aa_q, fa_q;

  assign ack = mem_req && mem_ack;

  // opcode of the running instruction and accesses made since its fetch
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      op_q <= OP_NO_OPERATION;
      cnt_q <= 2'h0;
    end else if (ack && opcode_fetch) begin
      op_q <= mem_rdata;
      cnt_q <= 2'h0;
    end else if (ack) begin
      cnt_q <= cnt_q + 2'h1;
    end
  end

  // last two bytes read and last access address
  always_ff @(posedge mclk) begin
    if (ack) begin
      aa_q <= mem_addr;
      d0_q <= mem_rdata;
      d1_q <= d0_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (ack && opcode_fetch) begin
      fa_q <= mem_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
    && $stable(mem_we) && $stable(mem_wdata)) else $error("request changed before ack");
  req_drop_a: assert property (ack |=> !mem_req)
    else $error("request not dropped after ack");
  idle_step_a: assert property (ack && opcode_fetch && mem_rdata == OP_NO_OPERATION
    |-> ##[2:4] (mem_req && opcode_fetch && mem_addr == aa_q + 16'h0001)) else $error("no-op step wrong");
  direct_addr_a: assert property (ack && !opcode_fetch && cnt_q == 2'h1
    && (op_q == OP_LOAD_ACC_DIRECT || op_q == OP_STORE_PAIR_DIRECT || op_q == OP_STA)
    |-> ##[2:4] (mem_req && !opcode_fetch && mem_addr == {d0_q, d1_q})) else $error("direct address wrong");
  load_len_a: assert property (ack && !opcode_fetch && op_q == OP_LOAD_ACC_DIRECT && cnt_q == 2'h2
    |-> ##[2:4] (mem_req && opcode_fetch && mem_addr == fa_q + 16'h0003)) else $error("load length wrong");
  push_down_a: assert property (ack && mem_we && !opcode_fetch && ((op_q == OP_CALL && cnt_q == 2'h2)
    || ((op_q & MASK_PAIR) == PAT_PUSH && cnt_q == 2'h0))
    |-> ##[2:4] (mem_req && mem_we && mem_addr == aa_q - 16'h0001)) else $error("push order wrong");
  pair_store_up_a: assert property (ack && mem_we && !opcode_fetch && op_q == OP_STORE_PAIR_DIRECT && cnt_q == 2'h2
    |-> ##[2:4] (mem_req && mem_we && mem_addr == aa_q + 16'h0001)) else $error("pair store order wrong");
  pop_up_a: assert property (ack && !opcode_fetch && op_q == OP_RET && cnt_q == 2'h0
    |-> ##[2:4] (mem_req && !mem_we && mem_addr == aa_q + 16'h0001)) else $error("pop order wrong");
  ret_back_a: assert property (ack && !opcode_fetch && op_q == OP_RET && cnt_q == 2'h1
    |-> ##[2:4] (mem_req && opcode_fetch && mem_addr == {d0_q, d1_q})) else $error("return target wrong");

  cover property (ack && !opcode_fetch && op_q == OP_RET);
  cover property (ack && mem_we && op_q == OP_STORE_PAIR_DIRECT);
  cover property (ack && op_q == OP_LOAD_ACC_DIRECT && cnt_q == 2'h2);
endmodule : oag_props

bind oag_core oag_props i_props (.mclk(mclk), .reset_n(reset_n), .mem_req(mem_req), .mem_we(mem_we),
  .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
  .opcode_fetch(opcode_fetch), .unknown_opcode(unknown_opcode));

`default_nettype wire

/* testbench/testbench.sv */
// testbench: runs small programs on the decode core and checks its writes
// assumes oag_core, the memory model and the checker bind are compiled first
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic mclk, reset_n, mem_req, mem_we, mem_ack, opcode_fetch, unknown_opcode;
  logic [1:0] wait_cyc;
  logic [15:0] mem_addr;
  logic [7:0] mem_wdata, mem_rdata;
  int err_count;
  int checks_done;
  int cyc;

  oag_core i_dut (.mclk(mclk), .reset_n(reset_n), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .opcode_fetch(opcode_fetch),
    .unknown_opcode(unknown_opcode));
  oag_mem_model i_mem (.mclk(mclk), .wait_cyc(wait_cyc), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // all programs finish well inside this many cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // reset, clear memory, load n program bytes at 0, release
  task automatic boot(input logic [511:0] v, input int n, input logic [1:0] w);
    @(posedge mclk);
    reset_n <= 1'b0;
    wait_cyc <= w;
    repeat (16) @(posedge mclk);
    for (int i = 0; i < 65536; i++) begin
      i_mem.ram[i] = (i < n) ? v[8*(n-1-i) +: 8] : 8'h00;
    end
    reset_n <= 1'b1;
  endtask : boot

  task automatic exp_wr(input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (!(mem_req === 1'b1 && mem_ack === 1'b1 && mem_we === 1'b1) && n < 3000);
    if (n >= 3000) begin
      err_count++;
    end
    chk({8'h00, mem_addr, mem_wdata}, {8'h00, a, d});
  endtask : exp_wr

  // wait for the one-cycle flag of an opcode that is not implemented
  task automatic exp_unknown();
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (unknown_opcode !== 1'b1 && n < 3000);
    chk({31'h0000_0000, unknown_opcode}, 32'h0000_0001);
  endtask : exp_unknown

  task automatic t_misc();
    boot(432'h003a_0040_17d2_0c00_0100_5002_1717_d215_0012_1212_1211_0150_120a_1216_601e_003e_7712_0670_0221_ffff_2922_0140_d200_003e_5502_76c3_3300, 54, 2'h1);
    i_mem.ram[16'h4000] = 8'hc5;
    exp_wr(16'h5000, 8'h8a);
    exp_wr(16'h5001, 8'h2b);
    exp_wr(16'h5001, 8'h8a);
    exp_wr(16'h6000, 8'h77);
    exp_wr(16'h7000, 8'h77);
    exp_wr(16'h4001, 8'hfe);
    exp_wr(16'h4002, 8'hff);
    exp_wr(16'h7000, 8'h55);
    exp_unknown();
  endtask : t_misc

  task automatic t_stack();
    boot(184'h31_0020_2134_12e5_cd20_00d1_2100_0019_2200_3036_5ac3_1400, 23, 2'h2);
    i_mem.ram[16'h0020] = 8'hc9;
    exp_wr(16'h1fff, 8'h12);
    exp_wr(16'h1ffe, 8'h34);
    exp_wr(16'h1ffd, 8'h00);
    exp_wr(16'h1ffc, 8'h0a);
    exp_wr(16'h3000, 8'h34);
    exp_wr(16'h3001, 8'h12);
    exp_wr(16'h1234, 8'h5a);
  endtask : t_stack

  task automatic t_mult();
    boot(232'h3e_0216_031e_0021_0000_0608_2917_d213_0019_ce00_05c2_0b00_2240_00c3_0000, 29, 2'h0);
    exp_wr(16'h0040, 8'h00);
    exp_wr(16'h0041, 8'h06);
  endtask : t_mult

  initial begin
    reset_n = 1'b0;
    wait_cyc = 2'h0;
    t_misc();
    t_stack();
    t_mult();
    end_sim();
  end
endmodule : testbench

`default_nettype wire

/* verilog/oag_core.sv */
// operand address generation and decode for a small 8-bit processor subset
// assumes one memory on the bus answering each held request with a one-cycle ack
`timescale 1ns/1ps
`default_nettype none

module oag_core
  import oag_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  output logic mem_req,
  output logic mem_we,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [DATA_W-1:0] mem_wdata,
  input wire logic [DATA_W-1:0] mem_rdata,
  input wire logic mem_ack,
  output logic opcode_fetch,
  output logic unknown_opcode
);

  oag_state_type state_q;
  logic [15:0] pc_q;
  logic [15:0] sp_q;
  logic [7:0] rf_q [0:7];
  logic carry_q;
  logic zero_q;
  logic [7:0] op_q;
  logic [15:0] tmp_q;
  logic step_q;
  logic mem_req_q;
  logic mem_we_q;
  logic [15:0] mem_addr_q;
  logic [7:0] mem_wdata_q;
  logic fetch_q;
  logic unknown_q;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  function automatic logic [1:0] imm_bytes(input logic [7:0] op);
    logic [1:0] n;
    n = 2'd0;
    // direct load takes two address bytes
    if (op == OP_LOAD_ACC_DIRECT || op == OP_STA || op == OP_STORE_PAIR_DIRECT || op == OP_JMP ||
        op == OP_JUMP_CARRY_CLEAR || op == OP_JNZ || op == OP_CALL || (op & MASK_PAIR) == PAT_LOAD_PAIR_IMM) begin
      n = 2'd2;
    end else if ((op & MASK_REG) == PAT_MOVE_IMM || op == OP_ACI) begin
      n = 2'd1;
    end
    return n;
  endfunction : imm_bytes

  logic [1:0] rp;
  logic [2:0] dst;
  logic is_load_pair_imm, is_move_imm, is_double_add, is_push, is_pop, is_dcr;
  logic is_load_direct, is_sta, is_store_via_pair, is_load_via_pair, is_store_pair, is_call, is_ret;
  logic is_mem, two_byte;
  logic [15:0] pair_val;
  logic [15:0] hl;
  logic [7:0] push_hi;
  logic [7:0] push_lo;

  assign rp = op_q[5:4];
  assign dst = op_q[5:3];
  assign is_load_pair_imm = (op_q & MASK_PAIR) == PAT_LOAD_PAIR_IMM;
  assign is_move_imm = (op_q & MASK_REG) == PAT_MOVE_IMM;
  assign is_double_add = (op_q & MASK_PAIR) == PAT_DOUBLE_ADD;
  assign is_push = (op_q & MASK_PAIR) == PAT_PUSH;
  assign is_pop = (op_q & MASK_PAIR) == PAT_POP;
  assign is_dcr = (op_q & MASK_REG) == PAT_DCR;
  assign is_load_direct = op_q == OP_LOAD_ACC_DIRECT;
  assign is_sta = op_q == OP_STA;
  // second or third pair as pointer
  assign is_store_via_pair = op_q == OP_STORE_VIA_SECOND || op_q == OP_STORE_VIA_THIRD;
  assign is_load_via_pair = op_q == OP_LOAD_VIA_SECOND || op_q == OP_LOAD_VIA_THIRD;
  assign is_store_pair = op_q == OP_STORE_PAIR_DIRECT;
  assign is_call = op_q == OP_CALL;
  assign is_ret = op_q == OP_RET;
  assign two_byte = is_store_pair | is_push | is_pop | is_call | is_ret;
  assign is_mem = two_byte | is_load_direct | is_sta | is_store_via_pair | is_load_via_pair |
                  (is_move_imm && dst == REG_M);

  // high register is the upper address byte
  assign hl = {rf_q[REG_H], rf_q[REG_L]};
  assign pair_val = (rp == PAIR_SP) ? sp_q : {rf_q[{rp, 1'b0}], rf_q[{rp, 1'b1}]};
  assign push_hi = (rp == PAIR_SP) ? rf_q[REG_A] : rf_q[{rp, 1'b0}];
  assign push_lo = (rp == PAIR_SP) ? {6'h00, zero_q, carry_q} : rf_q[{rp, 1'b1}];

  ////////////////////////////////////////////////////////////////////////////
  // access address and data for the current state

  logic bus_state;
  logic [15:0] acc_addr;
  logic acc_we;
  logic [7:0] acc_wd;

  assign bus_state = state_q == ST_FETCH || state_q == ST_IMM_LO || state_q == ST_IMM_HI ||
                     state_q == ST_MEM;

  always_comb begin
    acc_addr = pc_q;
    acc_we = 1'b0;
    acc_wd = 8'h00;
    if (state_q == ST_MEM) begin
      acc_we = is_sta | is_store_via_pair | is_move_imm | is_store_pair | is_push | is_call;
      if (is_load_direct || is_sta) begin
        acc_addr = tmp_q;
        acc_wd = rf_q[REG_A];
      end else if (is_store_via_pair || is_load_via_pair) begin
        acc_addr = pair_val;
        acc_wd = rf_q[REG_A];
      end else if (is_move_imm) begin
        acc_addr = hl;
        acc_wd = tmp_q[7:0];
      end else if (is_store_pair) begin
        // pair stored at address and address plus one
        acc_addr = 16'(tmp_q + {15'h0000, step_q});
        acc_wd = step_q ? rf_q[REG_H] : rf_q[REG_L];
      end else if (is_push || is_call) begin
        acc_addr = 16'(sp_q - 16'h0001);
        // return address is the already advanced counter
        if (is_call) begin
          acc_wd = step_q ? pc_q[7:0] : pc_q[15:8];
        end else begin
          // high byte first so low byte lands lower
          acc_wd = step_q ? push_lo : push_hi;
        end
      end else begin
        acc_addr = sp_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus requests: load address, then hold request until acked

  logic acked;
  assign acked = mem_req_q & mem_ack;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      mem_req_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_addr_q <= PC_RESET;
      mem_wdata_q <= REG_RESET;
      fetch_q <= 1'b0;
    end else if (mem_req_q) begin
      if (mem_ack) begin
        mem_req_q <= 1'b0;
        mem_we_q <= 1'b0;
      end
    end else if (bus_state) begin
      mem_req_q <= 1'b1;
      mem_we_q <= acc_we;
      mem_addr_q <= acc_addr;
      mem_wdata_q <= acc_wd;
      fetch_q <= state_q == ST_FETCH;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer and architectural state

  logic [16:0] dad_sum;
  logic [8:0] aci_sum;
  logic [7:0] dcr_val;
  assign dad_sum = {1'b0, hl} + {1'b0, pair_val};
  assign aci_sum = {1'b0, rf_q[REG_A]} + {1'b0, tmp_q[7:0]} + {8'h00, carry_q};
  assign dcr_val = 8'(rf_q[dst] - 8'h01);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_q <= ST_FETCH;
      pc_q <= PC_RESET;
      sp_q <= SP_RESET;
      for (int i = 0; i < 8; i++) begin
        rf_q[i] <= REG_RESET;
      end
      carry_q <= 1'b0;
      zero_q <= 1'b0;
      op_q <= OP_NO_OPERATION;
      tmp_q <= 16'h0000;
      step_q <= 1'b0;
      unknown_q <= 1'b0;
    end else begin
      unknown_q <= 1'b0;
      case (state_q)
        ST_FETCH: begin
          if (acked) begin
            op_q <= mem_rdata;
            pc_q <= 16'(pc_q + 16'h0001);
            tmp_q <= 16'h0000;
            step_q <= 1'b0;
            state_q <= (imm_bytes(mem_rdata) != 2'd0) ? ST_IMM_LO : ST_EXEC;
          end
        end
        ST_IMM_LO: begin
          // first embedded byte is the low byte
          if (acked) begin
            tmp_q[7:0] <= mem_rdata;
            pc_q <= 16'(pc_q + 16'h0001);
            state_q <= (imm_bytes(op_q) == 2'd2) ? ST_IMM_HI : ST_EXEC;
          end
        end
        ST_IMM_HI: begin
          if (acked) begin
            tmp_q[15:8] <= mem_rdata;
            pc_q <= 16'(pc_q + 16'h0001);
            state_q <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          state_q <= ST_FETCH;
          if (is_mem) begin
            state_q <= ST_MEM;
          end else if (is_load_pair_imm) begin
            // stack pointer set by pair immediate load
            // high/low pair from two immediate bytes
            if (rp == PAIR_SP) begin
              sp_q <= tmp_q;
            end else begin
              rf_q[{rp, 1'b0}] <= tmp_q[15:8];
              rf_q[{rp, 1'b1}] <= tmp_q[7:0];
            end
          end else if (is_move_imm) begin
            // code 000 is the upper second-pair register
            rf_q[dst] <= tmp_q[7:0];
          end else if (is_double_add) begin
            // pair added to itself doubles it
            {carry_q, rf_q[REG_H], rf_q[REG_L]} <= dad_sum;
          end else if (op_q == OP_ROTATE_LEFT_CARRY) begin
            {carry_q, rf_q[REG_A]} <= {rf_q[REG_A], carry_q};
          end else if (op_q == OP_JUMP_CARRY_CLEAR) begin
            if (!carry_q) begin
              pc_q <= tmp_q;
            end
          end else if (op_q == OP_JNZ) begin
            if (!zero_q) begin
              pc_q <= tmp_q;
            end
          end else if (op_q == OP_JMP) begin
            pc_q <= tmp_q;
          end else if (op_q == OP_ACI) begin
            {carry_q, rf_q[REG_A]} <= aci_sum;
            zero_q <= aci_sum[7:0] == 8'h00;
          end else if (is_dcr && dst != REG_M) begin
            rf_q[dst] <= dcr_val;
            zero_q <= dcr_val == 8'h00;
          end else if (op_q != OP_NO_OPERATION) begin
            unknown_q <= 1'b1;
          end
        end
        ST_MEM: begin
          if (acked) begin
            // predecrement on push, postincrement on pop
            if (is_push || is_call) begin
              sp_q <= 16'(sp_q - 16'h0001);
            end
            if (is_pop || is_ret) begin
              sp_q <= 16'(sp_q + 16'h0001);
            end
            if (is_load_direct || is_load_via_pair) begin
              rf_q[REG_A] <= mem_rdata;
            end
            // pop reads low byte then high byte
            if (is_pop) begin
              if (!step_q) begin
                if (rp == PAIR_SP) begin
                  carry_q <= mem_rdata[0];
                  zero_q <= mem_rdata[1];
                end else begin
                  rf_q[{rp, 1'b1}] <= mem_rdata;
                end
              end else begin
                rf_q[push_hi_idx(rp)] <= mem_rdata;
              end
            end
            if (is_ret) begin
              if (!step_q) begin
                tmp_q[7:0] <= mem_rdata;
              end else begin
                pc_q <= {mem_rdata, tmp_q[7:0]};
              end
            end
            // jump after return address is saved
            if (is_call && step_q) begin
              pc_q <= tmp_q;
            end
            if (two_byte && !step_q) begin
              step_q <= 1'b1;
            end else begin
              state_q <= ST_FETCH;
            end
          end
        end
        default: begin
          state_q <= ST_FETCH;
        end
      endcase
    end
  end

  function automatic logic [2:0] push_hi_idx(input logic [1:0] p);
    return (p == PAIR_SP) ? REG_A : {p, 1'b0};
  endfunction : push_hi_idx

  assign mem_req = mem_req_q;
  assign mem_we = mem_we_q;
  assign mem_addr = mem_addr_q;
  assign mem_wdata = mem_wdata_q;
  assign opcode_fetch = fetch_q;
  assign unknown_opcode = unknown_q;

endmodule : oag_core

`default_nettype wire
